// ---- shared/bles_consts.svh ----
/*
 * Constants of the byte-lane steering unit: transfer-width codes, lane
 * geometry and power-up timing.
 * Assumes inclusion by its bare name from the package and the design.
 */
`ifndef BLES_CONSTS_SVH
`define BLES_CONSTS_SVH

// Transfer-width codes shared by the core side and the bus side
`define BLES_SIZE_BYTE 2'h0
`define BLES_SIZE_HALF 2'h1
`define BLES_SIZE_WORD 2'h3

// Lane geometry of the 32-bit data bus
`define BLES_LANE_BITS 8
`define BLES_LANES 4
`define BLES_OFF_ONE 2'h1
`define BLES_HALF_FLIP 2'h2
`define BLES_BE_ALL 4'hf
`define BLES_BE_LOW 4'h1
`define BLES_BE_HIGH 4'h8
`define BLES_BE_PAIR 4'h3

// Clock and the settle time of the byte-order strap after reset release
`define BLES_CLK_NS 4
`define BLES_LOCK_NS 12
`define BLES_LOCK_CYCLES ((`BLES_LOCK_NS + `BLES_CLK_NS - 1) / `BLES_CLK_NS)

`endif

// ---- shared/bles_pkg.sv ----
/*
 * Types of the byte-lane steering unit.
 * Assumes bles_consts.svh is on the include path.
 */
`include "bles_consts.svh"

package bles_pkg;

	// Transfer-width code
	typedef logic [1:0] bles_size_t;

	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		ST_WAIT_MODE = 3'b001,
		ST_IDLE = 3'b010,
		ST_BUS = 3'b100
	} bles_state_t;

endpackage : bles_pkg

// ---- hdl/bles_steer.sv ----
/*
 * Byte-lane steering between a 32-bit core load/store port and the
 * external 32-bit data bus, in either byte order chosen by a strap.
 * Assumes one outstanding transfer, bus_ack from logic on clk, and a
 * strap pin that is stable from power-up on.
 */
`timescale 1ns/100ps
`include "bles_consts.svh"

module bles_steer #(
	parameter int LOCK_CYCLES = `BLES_LOCK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Byte-order strap pin
	input wire logic big_endian_strap,
	// Core request
	input wire logic core_valid,
	input wire logic core_write,
	input wire logic core_fetch,
	input wire logic core_unsigned,
	input wire bles_pkg::bles_size_t core_size,
	input wire logic [31:0] core_addr,
	input wire logic [31:0] core_wdata,
	output logic core_ready_reg,
	// Core answer
	output logic result_valid_reg,
	output logic [31:0] result_reg,
	output logic mode_big_reg,
	// External data bus
	output logic bus_req_reg,
	output logic bus_write_reg,
	output bles_pkg::bles_size_t bus_size_reg,
	output logic [31:0] bus_addr_reg,
	output logic [3:0] bus_be_reg,
	output logic [31:0] bus_wdata_reg,
	input wire logic bus_ack,
	input wire logic [31:0] bus_rdata
);
	import bles_pkg::*;

	// Lowest lane of a sub-word item; halfwords sit on even offsets
	function automatic logic [1:0] lane_of(input bles_size_t sz, input logic [1:0] off,
		input logic big);
		// Bit 0 of a halfword offset is dropped so a pair never runs past lane 3
		if (sz == `BLES_SIZE_HALF)
			lane_of = big ? ({off[1], 1'b0} ^ `BLES_HALF_FLIP) : {off[1], 1'b0};
		else
			lane_of = big ? ~off : off;
	endfunction : lane_of

	bles_state_t state_reg;
	logic strap_meta_reg;
	logic strap_sync_reg;
	logic [3:0] lock_cnt_reg;
	logic op_write_reg;
	logic op_fetch_reg;
	logic op_unsigned_reg;
	bles_size_t op_size_reg;
	logic [1:0] op_lane_reg;
	logic take;
	logic [7:0] rd_byte;
	logic [15:0] rd_half;
	logic [31:0] result_next;
	logic [1:0] req_lane;

	assign take = (state_reg == ST_IDLE) && core_ready_reg && core_valid;
	assign req_lane = lane_of(core_size, core_addr[1:0], mode_big_reg);

	// Two-stage synchroniser for the strap pin
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_meta_reg <= 1'b0;
			strap_sync_reg <= 1'b0;
		end else begin
			strap_meta_reg <= big_endian_strap;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// Byte order follows the synchronised strap on every cycle of ST_WAIT_MODE, then frozen
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_cnt_reg <= 4'h0;
			mode_big_reg <= 1'b0;
		end else if (state_reg == ST_WAIT_MODE) begin
			lock_cnt_reg <= lock_cnt_reg + 4'h1;
			mode_big_reg <= strap_sync_reg;
		end
	end

	// Sequencer: wait for mode, accept one request, wait for the bus
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_WAIT_MODE;
			core_ready_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_WAIT_MODE: begin
					if (lock_cnt_reg >= 4'(LOCK_CYCLES + 2)) begin
						state_reg <= ST_IDLE;
						core_ready_reg <= 1'b1;
					end
				end
				ST_IDLE: begin
					if (take) begin
						state_reg <= ST_BUS;
						core_ready_reg <= 1'b0;
					end
				end
				ST_BUS: begin
					if (bus_ack) begin
						state_reg <= ST_IDLE;
						core_ready_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	// Bus request: address and width pass through unchanged in both modes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_req_reg <= 1'b0;
			bus_write_reg <= 1'b0;
			bus_size_reg <= `BLES_SIZE_WORD;
			bus_addr_reg <= 32'h0000_0000;
		end else begin
			bus_req_reg <= take;
			if (take) begin
				bus_write_reg <= core_write;
				bus_size_reg <= core_size;
				bus_addr_reg <= core_addr;
			end
		end
	end

	// Store lanes and enables follow the same mapping as loads
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_be_reg <= 4'h0;
			bus_wdata_reg <= 32'h0000_0000;
		end else if (take) begin
			unique case (core_size)
				`BLES_SIZE_BYTE: begin
					bus_be_reg <= `BLES_BE_LOW << req_lane;
					bus_wdata_reg <= 32'(core_wdata[7:0]) << (req_lane * 8);
				end
				`BLES_SIZE_HALF: begin
					bus_be_reg <= `BLES_BE_PAIR << req_lane;
					bus_wdata_reg <= 32'(core_wdata[15:0]) << (req_lane * 8);
				end
				default: begin
					bus_be_reg <= `BLES_BE_ALL;
					bus_wdata_reg <= core_wdata;
				end
			endcase
		end
	end

	// Operation kept for steering the answer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			op_write_reg <= 1'b0;
			op_fetch_reg <= 1'b0;
			op_unsigned_reg <= 1'b0;
			op_size_reg <= `BLES_SIZE_WORD;
			op_lane_reg <= 2'h0;
		end else if (take) begin
			op_write_reg <= core_write;
			op_fetch_reg <= core_fetch;
			op_unsigned_reg <= core_unsigned;
			op_size_reg <= core_size;
			op_lane_reg <= req_lane;
		end
	end

	// Load steering: pick the lane, extend; words and fetches pass verbatim
	always_comb begin
		rd_byte = bus_rdata[op_lane_reg * 8 +: 8];
		rd_half = bus_rdata[op_lane_reg * 8 +: 16];
		if (op_fetch_reg)
			result_next = bus_rdata;
		else if (op_size_reg == `BLES_SIZE_BYTE)
			result_next = op_unsigned_reg ? {24'h00_0000, rd_byte}
				: {{24{rd_byte[7]}}, rd_byte};
		else if (op_size_reg == `BLES_SIZE_HALF)
			result_next = op_unsigned_reg ? {16'h0000, rd_half} : {{16{rd_half[15]}}, rd_half};
		else
			result_next = bus_rdata;
	end

	// Answer to the core, one pulse per completed transfer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			result_valid_reg <= 1'b0;
			result_reg <= 32'h0000_0000;
		end else begin
			result_valid_reg <= (state_reg == ST_BUS) && bus_ack;
			if ((state_reg == ST_BUS) && bus_ack && !op_write_reg)
				result_reg <= result_next;
		end
	end

	// Checks
	logic ack_load;
	assign ack_load = (state_reg == ST_BUS) && bus_ack && !op_write_reg;

	a_ubyte_zero_fill: assert property (@(posedge clk) disable iff (!reset_n)
		ack_load && !op_fetch_reg && op_size_reg == `BLES_SIZE_BYTE && op_unsigned_reg
		|=> result_reg[31:8] == 24'h00_0000 && result_reg[7:0] == $past(rd_byte))
		else $error("unsigned byte load not zero filled");
	a_addr_size_pass: assert property (@(posedge clk) disable iff (!reset_n)
		take |=> bus_req_reg && bus_addr_reg == $past(core_addr)
			&& bus_size_reg == $past(core_size))
		else $error("bus address or width altered");
	a_byte_one_lane: assert property (@(posedge clk) disable iff (!reset_n)
		bus_req_reg && bus_size_reg == `BLES_SIZE_BYTE |-> $onehot(bus_be_reg))
		else $error("byte access enables more than one lane");
	a_offset_one_lane: assert property (@(posedge clk) disable iff (!reset_n)
		ack_load && !op_fetch_reg && op_size_reg == `BLES_SIZE_BYTE
			&& bus_addr_reg[1:0] == `BLES_OFF_ONE
		|=> result_reg[7:0] == (mode_big_reg ? $past(bus_rdata[23:16]) : $past(bus_rdata[15:8])))
		else $error("offset one byte taken from wrong lane");
	a_word_untouched: assert property (@(posedge clk) disable iff (!reset_n)
		ack_load && (op_fetch_reg || op_size_reg == `BLES_SIZE_WORD)
		|=> result_reg == $past(bus_rdata))
		else $error("word or fetch data altered");
	a_word_store: assert property (@(posedge clk) disable iff (!reset_n)
		take && core_size == `BLES_SIZE_WORD
		|=> bus_be_reg == `BLES_BE_ALL && bus_wdata_reg == $past(core_wdata))
		else $error("word store altered");
	a_mode_held: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg != ST_WAIT_MODE |=> $stable(mode_big_reg))
		else $error("byte order changed during session");
	a_store_lanes: assert property (@(posedge clk) disable iff (!reset_n)
		bus_req_reg && bus_write_reg && bus_size_reg == `BLES_SIZE_BYTE
		|-> bus_be_reg == (mode_big_reg ? (`BLES_BE_HIGH >> bus_addr_reg[1:0])
			: (`BLES_BE_LOW << bus_addr_reg[1:0])))
		else $error("byte store on wrong lane");
	a_answer_bound: assert property (@(posedge clk) disable iff (!reset_n)
		(take || ((state_reg == ST_BUS) && !bus_ack)) |=> state_reg == ST_BUS)
		else $error("sequencer left bus wait early");

	c_byte_load_big: cover property (@(posedge clk) disable iff (!reset_n)
		ack_load && mode_big_reg && op_size_reg == `BLES_SIZE_BYTE);
	c_half_store: cover property (@(posedge clk) disable iff (!reset_n)
		take && core_write && core_size == `BLES_SIZE_HALF);
	c_fetch_done: cover property (@(posedge clk) disable iff (!reset_n)
		ack_load && op_fetch_reg);

endmodule : bles_steer

// ---- tb/bles_mem_model.sv ----
/* Memory agent on the external data bus, four words, lane enables honoured.
 * Assumes one transfer at a time; answers after slow cycles. */
`timescale 1ns/100ps
module bles_mem_model (
	// Clock
	input wire logic clk,
	// Bus from the unit
	input wire logic bus_req_reg,
	input wire logic bus_write_reg,
	input wire logic [31:0] bus_addr_reg,
	input wire logic [3:0] bus_be_reg,
	input wire logic [31:0] bus_wdata_reg,
	// Answer delay
	input wire logic [1:0] slow,
	// Answer to the unit
	output logic bus_ack,
	output logic [31:0] bus_rdata
);
	logic [31:0] mem [4] = '{32'h8899_aabb, 32'h1122_3344, 32'h1122_3344, 32'hc0de_f00d};
	// Bit-number-preserving attach, no lane swap
	initial begin
		bus_ack = 1'b0;
		bus_rdata = 32'h0000_0000;
		forever begin
			@(posedge clk);
			#1;
			if (bus_req_reg) begin
				repeat (slow) begin
					@(posedge clk);
					#1;
				end
				for (int i = 0; i < 4; i++) begin
					if (bus_write_reg && bus_be_reg[i]) begin
						mem[bus_addr_reg[3:2]][i*8+:8] = bus_wdata_reg[i*8+:8];
					end
				end
				bus_rdata = mem[bus_addr_reg[3:2]];
				bus_ack = 1'b1;
				@(posedge clk);
				#1;
				bus_ack = 1'b0;
				bus_rdata = ~bus_rdata; // Stale data is not left on the bus
			end
		end
	end
endmodule : bles_mem_model

// ---- tb/bles_steer_tb.sv ----
/* Bench for the byte-lane steering unit in both byte orders.
 * Assumes bles_mem_model as the bus agent, preloaded with fixed words. */
`timescale 1ns/100ps
`include "bles_consts.svh"
module bles_steer_tb;
	import bles_pkg::*;
	localparam logic [31:0] W0 = 32'h8899_aabb;
	localparam logic [31:0] W1 = 32'h1122_3344;
	logic clk = 0, reset_n = 0, strap = 0, cv = 0, cw = 0, cf = 0, cu = 0, rdy, rv, mb, breq, bw, ack;
	bles_size_t cs = 2'h0, bsz;
	logic [31:0] ca = 0, cd = 0, rdata, res, baddr, bwd, swd;
	logic [3:0] be, sbe;
	logic [1:0] slow = 0;
	int n_errors = 0, tests_run = 0, cyc = 0;
	// Clock
	always #2 clk = ~clk;
	bles_steer #(.LOCK_CYCLES(1)) dut (.clk(clk), .reset_n(reset_n), .big_endian_strap(strap),
		.core_valid(cv), .core_write(cw), .core_fetch(cf), .core_unsigned(cu), .core_size(cs),
		.core_addr(ca), .core_wdata(cd), .core_ready_reg(rdy), .result_valid_reg(rv),
		.result_reg(res), .mode_big_reg(mb), .bus_req_reg(breq), .bus_write_reg(bw),
		.bus_size_reg(bsz), .bus_addr_reg(baddr), .bus_be_reg(be), .bus_wdata_reg(bwd),
		.bus_ack(ack), .bus_rdata(rdata));
	bles_mem_model mem_i (.clk(clk), .bus_req_reg(breq), .bus_write_reg(bw),
		.bus_addr_reg(baddr), .bus_be_reg(be), .bus_wdata_reg(bwd), .slow(slow),
		.bus_ack(ack), .bus_rdata(rdata));
	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	// One core transfer, bus side captured at the request
	task automatic acc(input logic w, f, u, input bles_size_t s, input logic [31:0] a, d);
		int n;
		n = 0;
		while (rdy !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1 n++;
		end
		{cv, cw, cf, cu, cs, ca, cd} = {1'b1, w, f, u, s, a, d};
		@(posedge clk);
		#1 cv = 0;
		chk("bus_req", 1, breq);
		chk("bus_write", w, bw);
		chk("bus_addr", a, baddr);
		chk("bus_size", s, bsz);
		sbe = be;
		swd = bwd;
		n = 0;
		while (rv !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1 n++;
		end
		chk("done", 1, rv);
	endtask : acc
	task automatic do_reset(input logic big, input logic [1:0] sl);
		reset_n = 0;
		strap = big;
		slow = sl;
		repeat (8) @(posedge clk);
		#1 reset_n = 1;
		repeat (10) @(posedge clk);
		#1 chk("mode", big, mb);
	endtask : do_reset
	task automatic t_bytes(input logic big);
		logic [1:0] ln;
		for (int o = 0; o < 4; o++) begin
			ln = big ? 2'(3 - o) : 2'(o);
			acc(0, 0, 1, `BLES_SIZE_BYTE, 32'(o), 0);
			chk("ubyte", {24'h0, W0[ln*8+:8]}, res);
			chk("byte_be", 32'(4'h1 << ln), 32'(sbe));
		end
	endtask : t_bytes
	task automatic t_words;
		acc(0, 0, 0, `BLES_SIZE_WORD, 32'h0, 0);
		chk("word", W0, res);
		chk("word_be", 32'hf, 32'(sbe));
		acc(0, 1, 0, `BLES_SIZE_WORD, 32'hc, 0);
		chk("fetch", 32'hc0de_f00d, res);
	endtask : t_words
	task automatic t_store(input logic big, input logic [31:0] a);
		logic [1:0] ln, hl;
		logic [31:0] e;
		ln = big ? 2'h2 : 2'h1;
		hl = big ? 2'h0 : 2'h2;
		e = W1;
		e[ln*8+:8] = 8'h5c;
		e[hl*8+:16] = 16'hbeef;
		acc(1, 0, 0, `BLES_SIZE_BYTE, a, 32'h5c);
		chk("st_lane", 32'h5c, 32'(swd[ln*8+:8]));
		chk("st_be", 32'(4'h1 << ln), 32'(sbe));
		acc(1, 0, 0, `BLES_SIZE_HALF, a + 1, 32'hbeef);
		chk("st_hbe", 32'(4'h3 << hl), 32'(sbe));
		acc(0, 0, 0, `BLES_SIZE_WORD, a - 1, 0);
		chk("st_back", e, res);
	endtask : t_store
	// Half loads on both pairs, an odd half offset, and a sign-extended byte
	task automatic t_halves(input logic big);
		logic [1:0] hl;
		logic [15:0] h;
		logic [7:0] b;
		hl = big ? 2'h0 : 2'h2;
		acc(0, 0, 1, `BLES_SIZE_HALF, 32'h2, 0);
		chk("uhalf", {16'h0000, W0[hl*8+:16]}, res);
		chk("half_be", 32'(4'h3 << hl), 32'(sbe));
		acc(0, 0, 1, `BLES_SIZE_HALF, 32'h3, 0);
		chk("uhalf_odd", {16'h0000, W0[hl*8+:16]}, res);
		chk("half_odd_be", 32'(4'h3 << hl), 32'(sbe));
		hl = big ? 2'h2 : 2'h0;
		h = W0[hl*8+:16];
		acc(0, 0, 0, `BLES_SIZE_HALF, 32'h0, 0);
		chk("shalf", {{16{h[15]}}, h}, res);
		b = big ? W0[7:0] : W0[31:24];
		acc(0, 0, 0, `BLES_SIZE_BYTE, 32'h3, 0);
		chk("sbyte", {{24{b[7]}}, b}, res);
	endtask : t_halves
	task automatic t_hold(input logic big);
		strap = ~big;
		repeat (20) @(posedge clk);
		#1 chk("mode_hold", big, mb);
		acc(0, 0, 1, `BLES_SIZE_BYTE, 32'h1, 0);
		chk("hold_lane", {24'h0, W0[(big ? 16 : 8)+:8]}, res);
	endtask : t_hold
	// Little-endian with prompt bus, then big-endian with slow bus
	initial begin
		do_reset(0, 0);
		t_bytes(0);
		t_words;
		t_halves(0);
		t_store(0, 32'h5);
		t_hold(0);
		do_reset(1, 2);
		t_bytes(1);
		t_words;
		t_halves(1);
		t_store(1, 32'h9);
		t_hold(1);
		print_verdict;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			print_verdict;
		end
	end
endmodule : bles_steer_tb
